// >>> rtl/lslc_pkg.sv
// ****************************************************************
// Shared constants for the multiframe timing block
// ****************************************************************
package lslc_pkg;

	// Link geometry: octets per frame and frames per multiframe
	localparam int unsigned F_OCTETS    = 1;
	localparam int unsigned K_FRAMES    = 32;
	// Link clock ticks per local multiframe
	localparam int unsigned LMFC_PERIOD = (F_OCTETS * K_FRAMES) / 4;
	localparam int unsigned CNT_W       = 3;

	// Multiframe counter value
	typedef logic [CNT_W-1:0] lslc_cnt_t;

	// Last legal counter value before wrap
	localparam lslc_cnt_t CNT_MAX  = lslc_cnt_t'(LMFC_PERIOD - 1);
	localparam lslc_cnt_t CNT_ZERO = 3'h0;

	// Ticks from a sampled sync pulse to the counter reload
	localparam int unsigned SYSREF_DELAY_CYC = 2;

	// Register map
	localparam int unsigned ADDR_W         = 8;
	localparam logic [7:0]  CTRL_ADDR      = 8'h54;
	localparam int unsigned SINGLEDET_BIT  = 0;
	localparam int unsigned TX_OFF_LSB     = 8;
	localparam int unsigned RX_OFF_LSB     = 12;
	localparam int unsigned RBD_OFF_LSB    = 16;
	localparam int unsigned RBD_CNT_LSB    = 24;
	localparam int unsigned DESKEW_BIT     = 28;
	localparam logic        SINGLEDET_RST  = 1'b1;
	localparam lslc_cnt_t   OFFSET_RST     = 3'h0;

	// Elastic buffer depth in link clock ticks
	localparam int unsigned SPAN_W         = 5;
	localparam logic [4:0]  RBD_DEPTH      = 5'h10;
	localparam logic [4:0]  SPAN_MAX       = 5'h1F;

	// Receive link states
	typedef enum logic [1:0] {
		RX_SYNC,
		RX_WAIT_ILAS,
		RX_WAIT_REL,
		RX_DATA
	} lslc_rx_state_t;

	// Transmit link states
	typedef enum logic [1:0] {
		TX_CGS,
		TX_WAIT_LMFC,
		TX_DATA
	} lslc_tx_state_t;

endpackage

// >>> rtl/lslc_lmfc_counter.sv
`timescale 1ns/1ns
// ****************************************************************
// Local multiframe counter with offset reload
// ****************************************************************
module lslc_lmfc_counter (
	input  wire logic               mclk_i,
	input  wire logic               rst_n_i,
	input  wire logic               load_i,
	input  wire lslc_pkg::lslc_cnt_t offset_i,
	output lslc_pkg::lslc_cnt_t     cnt_o
);

	lslc_pkg::lslc_cnt_t cnt;       // Current count
	lslc_pkg::lslc_cnt_t next_cnt;  // Next count

	// Next count
	always_comb begin
		if (load_i) begin
			next_cnt = offset_i;
		end else if (cnt == lslc_pkg::CNT_MAX) begin
			next_cnt = lslc_pkg::CNT_ZERO;
		end else begin
			next_cnt = cnt + 3'h1;
		end
	end

	// Count register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cnt <= lslc_pkg::CNT_ZERO;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign cnt_o = cnt;

	AST_CNT_WRAP: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(cnt == lslc_pkg::CNT_MAX && !load_i) |=> (cnt == lslc_pkg::CNT_ZERO))
		else $error("Counter did not wrap");

endmodule

// >>> rtl/lslc_timing.sv
`timescale 1ns/1ns
// Summary of operation
// - Counter reloads two ticks after sampled pulse
// - Transmit and receive offsets are programmable
// - Reload takes offset value, not zero
// - Offset four delays boundary four ticks
// - Sync released only on multiframe boundary
// - Alignment sequence starts at next boundary
// - Deskew error when spread exceeds buffer
// - Later sync release counts as reinitialisation
// - Accepted pulse clears single-detect bit
// - Pulses ignored until register reset or re-arm write
// - Writing one re-arms pulse sampling
// - Zero delay offset releases at boundary
// - Counter runs zero to FK/4 minus one
// - Report ticks before boundary at last arrival
// - Offset N releases N ticks early
module lslc_timing (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic        transmit_csr_reset_n_i,
	input  wire logic        receive_csr_reset_n_i,
	input  wire logic        tx_link_reset_n_i,
	input  wire logic        rx_link_reset_n_i,
	input  wire logic        sysref_i,
	input  wire logic        csr_wr_i,
	input  wire logic        csr_rd_i,
	input  wire logic [7:0]  csr_addr_i,
	input  wire logic [31:0] csr_wdata_i,
	output logic      [31:0] csr_rdata_o,
	input  wire logic        rx_cgs_done_i,
	input  wire logic        rx_resync_req_i,
	input  wire logic        rx_first_r_i,
	input  wire logic        rx_last_r_i,
	input  wire logic        tx_sync_n_i,
	output logic             sync_n_o,
	output logic             tx_ilas_start_o,
	output logic             rx_release_o,
	output logic             rx_deskew_err_o,
	output logic             rx_reinit_o
);

	// Ticks before the next boundary for a given count
	function automatic lslc_pkg::lslc_cnt_t ticks_to_bnd(input lslc_pkg::lslc_cnt_t c);
		ticks_to_bnd = lslc_pkg::CNT_ZERO - c;
	endfunction

	// ****************************************************************
	// Control register
	// ****************************************************************
	logic                singledet, next_singledet;   // Sampling armed
	lslc_pkg::lslc_cnt_t tx_off, next_tx_off;         // Transmit counter offset
	lslc_pkg::lslc_cnt_t rx_off, next_rx_off;         // Receive counter offset
	lslc_pkg::lslc_cnt_t rbd_off, next_rbd_off;       // Early release offset
	logic [31:0]         rdata, next_rdata;           // Read data
	logic                ctrl_wr;                     // Write hits control word
	logic                sw_set;                      // Software re-arm
	logic                s0;                          // Accepted pulse sample
	lslc_pkg::lslc_cnt_t rbd_count;                   // Arrival status
	logic                deskew;                      // Deskew error flag

	assign ctrl_wr = csr_wr_i && (csr_addr_i == lslc_pkg::CTRL_ADDR);
	assign sw_set  = ctrl_wr && csr_wdata_i[lslc_pkg::SINGLEDET_BIT];

	// Register next values
	always_comb begin
		next_singledet = singledet;
		next_tx_off    = tx_off;
		next_rx_off    = rx_off;
		next_rbd_off   = rbd_off;
		next_rdata     = rdata;
		if (s0) begin
			next_singledet = 1'b0;
		end
		// Field writes; software set beats hardware clear
		if (ctrl_wr) begin
			next_tx_off  = csr_wdata_i[lslc_pkg::TX_OFF_LSB +: lslc_pkg::CNT_W];
			next_rx_off  = csr_wdata_i[lslc_pkg::RX_OFF_LSB +: lslc_pkg::CNT_W];
			next_rbd_off = csr_wdata_i[lslc_pkg::RBD_OFF_LSB +: lslc_pkg::CNT_W];
			if (sw_set) begin
				next_singledet = 1'b1;
			end
		end
		// Read returns live status; unmapped reads give zero
		if (csr_rd_i) begin
			if (csr_addr_i == lslc_pkg::CTRL_ADDR) begin
				next_rdata = 32'h0;
				next_rdata[lslc_pkg::SINGLEDET_BIT] = singledet;
				next_rdata[lslc_pkg::TX_OFF_LSB +: lslc_pkg::CNT_W] = tx_off;
				next_rdata[lslc_pkg::RX_OFF_LSB +: lslc_pkg::CNT_W] = rx_off;
				next_rdata[lslc_pkg::RBD_OFF_LSB +: lslc_pkg::CNT_W] = rbd_off;
				next_rdata[lslc_pkg::RBD_CNT_LSB +: lslc_pkg::CNT_W] = rbd_count;
				next_rdata[lslc_pkg::DESKEW_BIT] = deskew;
			end else begin
				next_rdata = 32'h0;
			end
		end
		if (!transmit_csr_reset_n_i || !receive_csr_reset_n_i) begin
			next_singledet = lslc_pkg::SINGLEDET_RST;
			next_tx_off    = lslc_pkg::OFFSET_RST;
			next_rx_off    = lslc_pkg::OFFSET_RST;
			next_rbd_off   = lslc_pkg::OFFSET_RST;
		end
	end

	// Register storage
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			singledet <= lslc_pkg::SINGLEDET_RST;
			tx_off    <= lslc_pkg::OFFSET_RST;
			rx_off    <= lslc_pkg::OFFSET_RST;
			rbd_off   <= lslc_pkg::OFFSET_RST;
			rdata     <= 32'h0;
		end else begin
			singledet <= next_singledet;
			tx_off    <= next_tx_off;
			rx_off    <= next_rx_off;
			rbd_off   <= next_rbd_off;
			rdata     <= next_rdata;
		end
	end

	assign csr_rdata_o = rdata;

	// ****************************************************************
	// Sync pulse pipeline and counters
	// ****************************************************************
	logic                next_s0;                     // Gated sample
	logic                s1, next_s1;                 // Delay stage, drives reload
	lslc_pkg::lslc_cnt_t lat_tx, next_lat_tx;         // Offset in use, transmit
	lslc_pkg::lslc_cnt_t lat_rx, next_lat_rx;         // Offset in use, receive
	lslc_pkg::lslc_cnt_t tx_cnt;                      // Transmit count
	lslc_pkg::lslc_cnt_t rx_cnt;                      // Receive count

	// Pulse sampling; disarmed pulses never enter the pipe
	always_comb begin
		// ignore pulses while disarmed
		// Held pulse taken once: the arm bit clears one edge late
		next_s0     = sysref_i && singledet && !s0;
		next_s1     = s0;
		next_lat_tx = lat_tx;
		next_lat_rx = lat_rx;
		if (s0) begin
			next_lat_tx = tx_off;
			next_lat_rx = rx_off;
		end
	end

	// Pipeline registers
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			s0     <= 1'b0;
			s1     <= 1'b0;
			lat_tx <= lslc_pkg::OFFSET_RST;
			lat_rx <= lslc_pkg::OFFSET_RST;
		end else begin
			s0     <= next_s0;
			s1     <= next_s1;
			lat_tx <= next_lat_tx;
			lat_rx <= next_lat_rx;
		end
	end

	// Counters run free across link resets, so phase survives them
	lslc_lmfc_counter u_tx_cnt (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.load_i   (s1),
		.offset_i (lat_tx),
		.cnt_o    (tx_cnt)
	);

	lslc_lmfc_counter u_rx_cnt (
		.mclk_i   (mclk_i),
		.rst_n_i  (rst_n_i),
		.load_i   (s1),
		.offset_i (lat_rx),
		.cnt_o    (rx_cnt)
	);

	// ****************************************************************
	// Receive link timing
	// ****************************************************************
	lslc_pkg::lslc_rx_state_t rx_st, next_rx_st;      // Receive state
	logic                     sync_n, next_sync_n;    // Sync line level
	logic                     est, next_est;          // Link established once
	logic                     reinit, next_reinit;    // Reinit pulse
	logic                     rel, next_rel;          // Buffer released
	logic                     first_seen, next_first_seen; // Earliest lane seen
	logic [4:0]               span, next_span;        // Ticks since earliest lane
	lslc_pkg::lslc_cnt_t      next_rbd_count;         // Arrival status
	logic                     next_deskew;            // Deskew error

	// Receive next state
	always_comb begin
		next_rx_st      = rx_st;
		next_sync_n     = sync_n;
		next_est        = est;
		next_reinit     = 1'b0;
		next_rel        = rel;
		next_first_seen = first_seen;
		next_span       = span;
		next_rbd_count  = rbd_count;
		next_deskew     = deskew;
		// Span saturates so a lost lane cannot wrap it
		if (rx_first_r_i && !first_seen) begin
			next_first_seen = 1'b1;
			next_span       = 5'h0;
		end else if (first_seen && span != lslc_pkg::SPAN_MAX) begin
			next_span = span + 5'h1;
		end
		case (rx_st)
			lslc_pkg::RX_SYNC: begin
				next_sync_n     = 1'b0;
				next_first_seen = 1'b0;
				if (rx_cgs_done_i && rx_cnt == lslc_pkg::CNT_ZERO) begin
					next_sync_n = 1'b1;
					next_est    = 1'b1;
					next_reinit = est;
					next_rx_st  = lslc_pkg::RX_WAIT_ILAS;
				end
			end
			lslc_pkg::RX_WAIT_ILAS: begin
				if (rx_last_r_i) begin
					next_rbd_count = ticks_to_bnd(rx_cnt);
					next_rx_st     = lslc_pkg::RX_WAIT_REL;
				end
			end
			lslc_pkg::RX_WAIT_REL: begin
				if (rx_cnt == ticks_to_bnd(rbd_off)) begin
					next_rel   = 1'b1;
					next_deskew = deskew || (span > lslc_pkg::RBD_DEPTH);
					next_rx_st = lslc_pkg::RX_DATA;
				end
			end
			default: begin
			end
		endcase
		// Resync request drops sync from any later state
		if (rx_resync_req_i && rx_st != lslc_pkg::RX_SYNC) begin
			next_rx_st  = lslc_pkg::RX_SYNC;
			next_sync_n = 1'b0;
			next_rel    = 1'b0;
		end
		// Link reset keeps the established flag for reinit detection
		if (!rx_link_reset_n_i) begin
			// No reinit pulse or new link without a real release
			next_est        = est;
			next_reinit     = 1'b0;
			next_rx_st      = lslc_pkg::RX_SYNC;
			next_sync_n     = 1'b0;
			next_rel        = 1'b0;
			next_first_seen = 1'b0;
			next_deskew     = 1'b0;
		end
	end

	// Receive registers
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rx_st      <= lslc_pkg::RX_SYNC;
			sync_n     <= 1'b0;
			est        <= 1'b0;
			reinit     <= 1'b0;
			rel        <= 1'b0;
			first_seen <= 1'b0;
			span       <= 5'h0;
			rbd_count  <= lslc_pkg::CNT_ZERO;
			deskew     <= 1'b0;
		end else begin
			rx_st      <= next_rx_st;
			sync_n     <= next_sync_n;
			est        <= next_est;
			reinit     <= next_reinit;
			rel        <= next_rel;
			first_seen <= next_first_seen;
			span       <= next_span;
			rbd_count  <= next_rbd_count;
			deskew     <= next_deskew;
		end
	end

	assign sync_n_o        = sync_n;
	assign rx_reinit_o     = reinit;
	assign rx_release_o    = rel;
	assign rx_deskew_err_o = deskew;

	// ****************************************************************
	// Transmit link timing
	// ****************************************************************
	lslc_pkg::lslc_tx_state_t tx_st, next_tx_st;      // Transmit state
	logic                     ilas, next_ilas;        // Start pulse

	// Transmit next state
	always_comb begin
		next_tx_st = tx_st;
		next_ilas  = 1'b0;
		case (tx_st)
			lslc_pkg::TX_CGS: begin
				if (tx_sync_n_i) begin
					next_tx_st = lslc_pkg::TX_WAIT_LMFC;
				end
			end
			lslc_pkg::TX_WAIT_LMFC: begin
				if (!tx_sync_n_i) begin
					next_tx_st = lslc_pkg::TX_CGS;
				end else if (tx_cnt == lslc_pkg::CNT_ZERO) begin
					next_ilas  = 1'b1;
					next_tx_st = lslc_pkg::TX_DATA;
				end
			end
			default: begin
				if (!tx_sync_n_i) begin
					next_tx_st = lslc_pkg::TX_CGS;
				end
			end
		endcase
		if (!tx_link_reset_n_i) begin
			next_tx_st = lslc_pkg::TX_CGS;
			next_ilas  = 1'b0;
		end
	end

	// Transmit registers
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			tx_st <= lslc_pkg::TX_CGS;
			ilas  <= 1'b0;
		end else begin
			tx_st <= next_tx_st;
			ilas  <= next_ilas;
		end
	end

	assign tx_ilas_start_o = ilas;

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_SYSREF_RELOAD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s0 |-> ##2 (rx_cnt == lat_rx && tx_cnt == lat_tx))
		else $error("Counter not reloaded two ticks after sample");
	AST_OFF5_BOUNDARY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(s1 && lat_tx == 3'h5) |-> ##1 (tx_cnt == 3'h5) ##3 (tx_cnt == lslc_pkg::CNT_ZERO))
		else $error("Offset five boundary not three ticks later");
	AST_OFF4_BOUNDARY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(s1 && lat_tx == 3'h4) |-> ##5 (tx_cnt == lslc_pkg::CNT_ZERO))
		else $error("Offset four boundary not four ticks later");
	AST_SINGLEDET_CLR: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(s0 && !sw_set && transmit_csr_reset_n_i && receive_csr_reset_n_i) |=> !singledet)
		else $error("Single-detect not cleared by pulse");
	AST_IGNORE_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!singledet |=> !s0 ##1 !s1)
		else $error("Pulse accepted while disarmed");
	AST_REARM: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		sw_set |=> singledet)
		else $error("Write of one did not re-arm");
	AST_SYNC_BOUNDARY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(sync_n_o) |-> ($past(rx_cnt) == lslc_pkg::CNT_ZERO))
		else $error("Sync released off boundary");
	AST_ILAS_BOUNDARY: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		tx_ilas_start_o |-> ($past(tx_cnt) == lslc_pkg::CNT_ZERO && $past(tx_sync_n_i)))
		else $error("Alignment start off boundary");
	AST_RELEASE_POINT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(rx_release_o) |-> ($past(rx_cnt) == ticks_to_bnd($past(rbd_off))))
		else $error("Buffer released at wrong tick");
	AST_REINIT_PULSE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		rx_reinit_o |-> ($rose(sync_n_o) ##1 !rx_reinit_o))
		else $error("Reinit pulse without sync release");

endmodule

// >>> dv/lslc_conv_model.sv
`timescale 1ns/1ns
// ****************************************
// Converter model at the far end of both links
// ****************************************
module lslc_conv_model #(
	parameter int unsigned SR_LAT = 3	// Own pulse-to-reset delay
) (
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sysref_i,
	input  wire logic       sync_n_i,	// Device receive request
	input  wire logic       tx_rel_i,	// Converter ready to receive
	input  wire logic [4:0] first_dly_i,	// Earliest lane skew
	input  wire logic [4:0] last_dly_i,	// Latest lane skew
	output logic            tx_sync_n_o,
	output logic            first_r_o,
	output logic            last_r_o
);
	logic [2:0] cnt;	// Own multiframe counter
	logic [3:0] sr_dly;	// Reset countdown
	logic       sync_q;	// Request level last cycle
	logic       armed;	// Release seen, boundary pending
	logic [4:0] tmr;	// Ticks into sequence, saturating

	// Behavioural, one process; synthesis is not a goal here
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cnt <= 3'h0;
			sr_dly <= 4'h0;
			sync_q <= 1'b0;
			armed <= 1'b0;
			tmr <= 5'h1F;
			tx_sync_n_o <= 1'b0;
		end else begin
			// Counter reset a fixed delay after the pulse
			if (sysref_i && sr_dly == 4'h0) begin
				sr_dly <= 4'(SR_LAT);
			end else if (sr_dly != 4'h0) begin
				sr_dly <= sr_dly - 4'h1;
			end
			cnt <= (sr_dly == 4'h1) ? 3'h0 : cnt + 3'h1;
			if (!tx_rel_i) begin
				tx_sync_n_o <= 1'b0;
			end else if (cnt == 3'h0) begin
				tx_sync_n_o <= 1'b1;
			end
			sync_q <= sync_n_i;
			if (!sync_n_i) begin
				armed <= 1'b0;
				tmr <= 5'h1F;
			end else if (!sync_q) begin
				armed <= 1'b1;
			end else if (armed && cnt == 3'h0) begin
				armed <= 1'b0;
				tmr <= 5'h0;
			end else if (tmr != 5'h1F) begin
				tmr <= tmr + 5'h1;
			end
		end
	end

	// Lane arrivals as single pulses; skews chosen by the bench
	assign first_r_o = (tmr == first_dly_i) && (tmr != 5'h1F);
	assign last_r_o  = (tmr == last_dly_i) && (tmr != 5'h1F);
endmodule

// >>> dv/lslc_timing_tb_top.sv
`timescale 1ns/1ns
// ****************************************
// Bench for the multiframe timing block
// ****************************************
module lslc_timing_tb_top;
	localparam logic [7:0] CA = lslc_pkg::CTRL_ADDR;	// Control word
	logic        mclk_i = 1'b0;	// Link clock
	logic        rst_n_i, tcsr_n, rcsr_n, tlrst_n, rlrst_n, sysref, wr, rd;
	logic        cgs, resync, tx_rel, first_r, last_r, tsync_n;
	logic        sync_n, ilas, rel_o, dsk, reinit;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [4:0]  fdly, ldly;	// Lane skews
	int          fails, checked, cyc, t_ref, t_sr, rx_o, tx_o, rbd_o;
	// Corner rows: tx, rx, rbd offsets, first and last skew
	int          tbl [4][5] = '{'{0, 0, 0, 1, 3}, '{4, 5, 0, 0, 2},
		'{5, 4, 5, 2, 6}, '{5, 4, 1, 0, 20}};

	// 50 ns link clock
	always #25 mclk_i = ~mclk_i;

	lslc_timing dut (
		.mclk_i                 (mclk_i),
		.rst_n_i                (rst_n_i),
		.transmit_csr_reset_n_i (tcsr_n),
		.receive_csr_reset_n_i  (rcsr_n),
		.tx_link_reset_n_i      (tlrst_n),
		.rx_link_reset_n_i      (rlrst_n),
		.sysref_i               (sysref),
		.csr_wr_i               (wr),
		.csr_rd_i               (rd),
		.csr_addr_i             (addr),
		.csr_wdata_i            (wdata),
		.csr_rdata_o            (rdata),
		.rx_cgs_done_i          (cgs),
		.rx_resync_req_i        (resync),
		.rx_first_r_i           (first_r),
		.rx_last_r_i            (last_r),
		.tx_sync_n_i            (tsync_n),
		.sync_n_o               (sync_n),
		.tx_ilas_start_o        (ilas),
		.rx_release_o           (rel_o),
		.rx_deskew_err_o        (dsk),
		.rx_reinit_o            (reinit)
	);

	lslc_conv_model conv (
		.mclk_i      (mclk_i),
		.rst_n_i     (rst_n_i),
		.sysref_i    (sysref),
		.sync_n_i    (sync_n),
		.tx_rel_i    (tx_rel),
		.first_dly_i (fdly),
		.last_dly_i  (ldly),
		.tx_sync_n_o (tsync_n),
		.first_r_o   (first_r),
		.last_r_o    (last_r)
	);

	// One cycle on; inputs change at the falling edge
	task automatic tk();
		@(negedge mclk_i);
		cyc++;
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic csr_wr(input logic [7:0] a, input logic [31:0] d);
		tk();
		addr = a;
		wdata = d;
		wr = 1'b1;
		tk();
		wr = 1'b0;
	endtask

	// Read data is valid one edge after the strobe
	task automatic csr_rd(input logic [7:0] a, output logic [31:0] d);
		tk();
		addr = a;
		rd = 1'b1;
		tk();
		rd = 1'b0;
		d = rdata;
	endtask

	task automatic pulse(input int len);
		tk();
		sysref = 1'b1;
		t_sr = cyc;
		repeat (len) tk();
		sysref = 1'b0;
	endtask

	// Counter equals the offset three cycles after the pulse cycle
	function automatic int cnt_at(input int t, input int off);
		return ((off + t - t_ref - 3) % 8 + 8) % 8;
	endfunction

	task automatic rx_bringup(input logic via_rs, input logic e_ri);
		int b, f, l, rl, rp;
		logic [31:0] d;
		tk();
		// Drop sync by resync request or else by link reset
		resync = via_rs;
		rlrst_n = via_rs;
		tk();
		resync = 1'b0;
		rlrst_n = 1'b1;
		b = cyc + (8 - cnt_at(cyc, rx_o)) % 8;
		while (cyc <= b) begin
			chk_bit("sync_n_o held", 1'b0, sync_n);
			tk();
		end
		chk_bit("sync_n_o", 1'b1, sync_n);
		chk_bit("rx_reinit_o", e_ri, reinit);
		f = -1;
		l = -1;
		rl = -1;
		rp = (8 - rbd_o) % 8;
		for (int g = 0; g < 60 && rl < 0; g++) begin
			tk();
			if (first_r === 1'b1) f = cyc;
			if (last_r === 1'b1) begin
				l = cyc;
				b = l + 1 + (rp - cnt_at(l + 1, rx_o) + 8) % 8;
			end
			if (rel_o === 1'b1) rl = cyc;
		end
		// Arrival on the release tick waits a full multiframe
		chk_word("release cycle", b + 1, rl);
		tk();
		if (b - f < 15 || b - f > 17) chk_bit("rx_deskew_err_o", b - f > 16, dsk);
		csr_rd(CA, d);
		chk_word("rbd count", (8 - cnt_at(l, rx_o)) % 8, {29'h0, d[26:24]});
	endtask

	task automatic tx_bringup();
		int a, b;
		tk();
		tlrst_n = 1'b0;
		tx_rel = 1'b0;
		tk();
		tlrst_n = 1'b1;
		tx_rel = 1'b1;
		a = -1;
		for (int g = 0; g < 20 && a < 0; g++) begin
			tk();
			if (tsync_n === 1'b1) a = cyc;
			chk_bit("ilas idle", 1'b0, ilas);
		end
		b = a + 1 + (8 - cnt_at(a + 1, tx_o)) % 8;
		while (cyc < b + 3) begin
			chk_bit("tx_ilas_start_o", cyc == b + 1, ilas);
			tk();
		end
	endtask

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Watchdog: the run needs under a thousand cycles
	initial begin
		repeat (4000) @(posedge mclk_i);
		fails++;
		stop_test();
	end

	initial begin
		logic [31:0] d, w;
		int tx, rx, rbd, fd, ld;
		rst_n_i = 1'b0;
		tcsr_n = 1'b1;
		rcsr_n = 1'b1;
		tlrst_n = 1'b0;
		rlrst_n = 1'b0;
		sysref = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h00000000;
		cgs = 1'b0;
		resync = 1'b0;
		tx_rel = 1'b0;
		fdly = 5'h00;
		ldly = 5'h00;
		void'($urandom(32'h8A5C));
		repeat (6) tk();
		rst_n_i = 1'b1;
		csr_rd(CA, d);
		chk_word("ctrl reset", 32'h00000001, d);
		csr_wr(8'h40, 32'hFFFFFFFF);
		csr_rd(8'h40, d);
		chk_word("unmapped read", 32'h00000000, d);
		csr_rd(CA, d);
		chk_word("ctrl after stray", 32'h00000001, d);
		cgs = 1'b1;
		// Offsets from the corner rows, then random ones
		for (int i = 0; i < 6; i++) begin
			if (i < 4) begin
				tx = tbl[i][0];
				rx = tbl[i][1];
				rbd = tbl[i][2];
				fd = tbl[i][3];
				ld = tbl[i][4];
			end else begin
				tx = $urandom_range(7);
				rx = $urandom_range(7);
				rbd = $urandom_range(7);
				fd = $urandom_range(3);
				ld = fd + $urandom_range(7);
			end
			w = 32'(1 + (tx << 8) + (rx << 12) + (rbd << 16));
			csr_wr(CA, w);
			csr_rd(CA, d);
			chk_word("ctrl fields", w, d & 32'h00077701);
			fdly = 5'(fd);
			ldly = 5'(ld);
			pulse(1);
			t_ref = t_sr;
			rx_o = rx;
			tx_o = tx;
			rbd_o = rbd;
			csr_rd(CA, d);
			chk_bit("single-detect", 1'b0, d[0]);
			rx_bringup(i % 2 == 1, i > 0);
			tx_bringup();
		end
		// Disarmed: new offsets and a pulse must not move the phase
		csr_wr(CA, 32'h00003600);
		// Release offset is used live, not latched by the pulse
		rbd_o = 0;
		pulse(1);
		csr_rd(CA, d);
		chk_word("ignored pulse", 32'h00003600, d & 32'h00077701);
		rx_bringup(1'b1, 1'b1);
		tx_bringup();
		// Either register reset re-arms; a long pulse counts once
		for (int i = 0; i < 2; i++) begin
			tk();
			rcsr_n = (i != 0);
			tcsr_n = (i == 0);
			tk();
			rcsr_n = 1'b1;
			tcsr_n = 1'b1;
			csr_rd(CA, d);
			chk_word("rearm", 32'h00000001, d & 32'h00077701);
			pulse(3);
			t_ref = t_sr;
			rx_o = 0;
			tx_o = 0;
			rbd_o = 0;
			rx_bringup(1'b0, 1'b1);
			tx_bringup();
		end
		stop_test();
	end
endmodule
